/* logic/pcs_top.sv */
// pcs_top: program counter sequencer with fetch port, decoder port and register slave
//
// Behaviour
// RULE_01 - pc steps by one after each fetch
// RULE_02 - flow events load their own address
// RULE_03 - taken condition discards prefetch, one idle cycle
// RULE_04 - false condition continues without idle cycle
// RULE_05 - pc is 13 bits, low byte readable/writable
// RULE_06 - upper five pc bits not software accessible
// RULE_07 - addresses 8K words of 16 bits
// RULE_08 - low-byte write replaces pc bits 7..0
// RULE_09 - software loads page latch before short jump
// RULE_10 - interrupt pushes pc plus one, loads 0004
// RULE_11 - call pushes pc plus one, loads target
// RULE_12 - returns pop stack top into pc
// RULE_13 - page latch ignores sequential page crossing
// RULE_14 - software sets page latch for far targets
// RULE_15 - jump target: latch bits 12..11, field 10..0
// RULE_16 - low-byte write takes bits 12..8 from latch
// RULE_17 - reset clears pc to 0000
// RULE_18 - pc changing instructions take two cycles
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module pcs_top
  import pcs_pkg::*;
#(
  parameter int PC_W   = PCS_PC_W,
  parameter int INSN_W = PCS_INSN_W,
  parameter int AW     = PCS_AXI_AW
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // axi4-lite write address
  input  wire logic [AW-1:0]        s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [AW-1:0]        s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // program flash fetch port
  output logic [PC_W-1:0]           flash_addr,
  input  wire logic [INSN_W-1:0]    flash_data,
  // instruction decoder
  output logic [INSN_W-1:0]         insn_word,
  output logic                      insn_valid,
  input  wire logic                 dec_jump,
  input  wire logic                 dec_call,
  input  wire logic                 dec_return,
  input  wire logic                 dec_skip,
  input  wire logic [PCS_TGT_W-1:0] dec_target,
  // interrupt entry
  input  wire logic                 irq_req,
  output logic                      irq_ack,
  // return stack
  output logic                      stk_push,
  output logic [PC_W-1:0]           stk_push_data,
  output logic                      stk_pop,
  input  wire logic [PC_W-1:0]      stk_pop_data
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  generate
    if (PC_W < 12 || PC_W > 16 || INSN_W < 1 || AW < 4 || AW > 16) begin : g_bad  // [RULE_07]
      $error("pcs_top: unsupported parameter set");
    end
  endgenerate

  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [7:0] idx);
    return a[AW-1:PCS_ADDR_LSB] == (AW-PCS_ADDR_LSB)'(idx);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [PC_W-1:0]   pc_r;
  logic [PC_W-1:0]   pc_nxt;
  pcs_fetch_t        st_r;
  pcs_fetch_t        st_nxt;
  logic [INSN_W-1:0] insn_r;
  logic [PC_W-9:0]   page_r;
  logic [PC_W-9:0]   page_nxt;
  logic              aw_have_r;
  logic              aw_have_nxt;
  logic [AW-1:0]     aw_addr_r;
  logic [AW-1:0]     aw_addr_nxt;
  logic              w_have_r;
  logic              w_have_nxt;
  logic [31:0]       w_data_r;
  logic [31:0]       w_data_nxt;
  logic              w_strb0_r;
  logic              w_strb0_nxt;
  logic              bvalid_r;
  logic              bvalid_nxt;
  logic [1:0]        bresp_r;
  logic [1:0]        bresp_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [1:0]        rresp_r;
  logic [1:0]        rresp_nxt;
  logic              dec_busy;
  logic              commit;
  logic              low_wr;

  pcs_seq_if #(.PC_W(PC_W)) sq ();

  // ---------------------------------------------------------------
  // next-address selector
  // ---------------------------------------------------------------
  pcs_next_addr #(.PC_W(PC_W)) u_next (
    .sq (sq.sel)
  );

  assign sq.pc       = pc_r;
  assign sq.st       = st_r;
  assign sq.irq      = irq_req;
  assign sq.low_wr   = low_wr;
  assign sq.low_data = w_data_r[PCS_LOW_W-1:0];
  assign sq.page     = page_r;
  assign sq.jump     = dec_jump;
  assign sq.call     = dec_call;
  assign sq.rtn      = dec_return;
  assign sq.skip     = dec_skip;
  assign sq.target   = dec_target;
  assign sq.rtn_addr = stk_pop_data;

  // ---------------------------------------------------------------
  // program counter and fetch state
  // ---------------------------------------------------------------
  assign insn_valid = (st_r == PCS_ST_RUN);
  assign dec_busy   = insn_valid && (dec_jump || dec_call || dec_return || dec_skip);

  always_comb begin
    pc_nxt = sq.pc_nxt;
    st_nxt = sq.st_nxt;
    if (rst) begin
      pc_nxt = PC_W'(PCS_RESET_VEC);                                  // [RULE_17]
      st_nxt = PCS_ST_FLUSH;
    end
  end

  always_ff @(posedge mclk) begin
    pc_r   <= pc_nxt;
    st_r   <= st_nxt;
    insn_r <= flash_data;
  end

  assign flash_addr    = pc_r;                                        // [RULE_05]
  assign insn_word     = insn_r;
  assign stk_push      = sq.push;
  assign stk_push_data = pc_r;                                        // [RULE_11] [RULE_10]
  assign stk_pop       = sq.pop;
  assign irq_ack       = sq.irq_take;

  // ---------------------------------------------------------------
  // axi write path, commit waits while the decoder moves the pc
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign commit        = aw_have_r && w_have_r && !bvalid_r && !dec_busy;
  assign low_wr        = commit && w_strb0_r && reg_hit(aw_addr_r, PCS_IDX_PC_LOW);  // [RULE_08]

  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb0_nxt = w_strb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    page_nxt    = page_r;                                             // [RULE_13]
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_strb0_nxt = s_axi_wstrb[0];
    end
    if (commit) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = PCS_RESP_OKAY;
      if (reg_hit(aw_addr_r, PCS_IDX_PAGE)) begin
        if (w_strb0_r) begin
          page_nxt = w_data_r[PC_W-9:0];                              // [RULE_14]
        end
      end else if (!reg_hit(aw_addr_r, PCS_IDX_PC_LOW)) begin
        bresp_nxt = PCS_RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rst) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b0;
      bresp_nxt   = PCS_RESP_OKAY;
      page_nxt    = (PC_W-8)'(PCS_PAGE_RST);
    end
  end

  always_ff @(posedge mclk) begin
    aw_have_r <= aw_have_nxt;
    aw_addr_r <= aw_addr_nxt;
    w_have_r  <= w_have_nxt;
    w_data_r  <= w_data_nxt;
    w_strb0_r <= w_strb0_nxt;
    bvalid_r  <= bvalid_nxt;
    bresp_r   <= bresp_nxt;
    page_r    <= page_nxt;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ---------------------------------------------------------------
  // axi read path
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = PCS_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (reg_hit(s_axi_araddr, PCS_IDX_PC_LOW)) begin
        rdata_nxt = 32'(pc_r[PCS_LOW_W-1:0]);                         // [RULE_05] [RULE_06]
      end else if (reg_hit(s_axi_araddr, PCS_IDX_PAGE)) begin
        rdata_nxt = 32'(page_r);
      end else begin
        rresp_nxt = PCS_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rst) begin
      rvalid_nxt = 1'b0;
      rdata_nxt  = 32'h0000_0000;
      rresp_nxt  = PCS_RESP_OKAY;
    end
  end

  always_ff @(posedge mclk) begin
    rvalid_r <= rvalid_nxt;
    rdata_r  <= rdata_nxt;
    rresp_r  <= rresp_nxt;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_seq_step;
    !dec_busy && !low_wr && !irq_req |=> pc_r == $past(pc_r) + PC_W'(1) && insn_valid;
  endproperty
  a_seq_step: assert property (p_seq_step)  // [RULE_01] [RULE_04]
    else $error("pc did not step by one");

  property p_jump_target;
    insn_valid && dec_jump && !dec_return && !dec_call
      |=> pc_r == {$past(page_r[PC_W-9:3]), $past(dec_target)};
  endproperty
  a_jump_target: assert property (p_jump_target)  // [RULE_15]
    else $error("jump target wrong");

  property p_change_idle;
    dec_busy |=> !insn_valid;
  endproperty
  a_change_idle: assert property (p_change_idle)  // [RULE_03] [RULE_18]
    else $error("prefetched word not discarded");

  property p_irq_entry;
    irq_ack |-> stk_push && stk_push_data == pc_r ##1 pc_r == PCS_IRQ_VEC && !insn_valid;
  endproperty
  a_irq_entry: assert property (p_irq_entry)  // [RULE_10]
    else $error("interrupt entry wrong");

  property p_call_push;
    insn_valid && dec_call && !dec_return |-> stk_push && stk_push_data == pc_r;
  endproperty
  a_call_push: assert property (p_call_push)  // [RULE_11]
    else $error("call did not push return address");

  property p_rtn_pop;
    insn_valid && dec_return |-> stk_pop ##1 pc_r == $past(stk_pop_data);
  endproperty
  a_rtn_pop: assert property (p_rtn_pop)  // [RULE_12]
    else $error("return did not load popped address");

  property p_low_write;
    low_wr |=> pc_r == {$past(page_r), $past(w_data_r[PCS_LOW_W-1:0])} && s_axi_bvalid;
  endproperty
  a_low_write: assert property (p_low_write)  // [RULE_08] [RULE_16]
    else $error("low byte write wrong");

  property p_page_hold;
    !commit |=> $stable(page_r);
  endproperty
  a_page_hold: assert property (p_page_hold)  // [RULE_13]
    else $error("page latch moved without a write");

  property p_reset_vec;
    @(posedge mclk) disable iff (1'b0) rst |=> pc_r == PCS_RESET_VEC && !insn_valid;
  endproperty
  a_reset_vec: assert property (p_reset_vec)  // [RULE_17]
    else $error("reset did not clear pc");

  property p_low_read;
    s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr, PCS_IDX_PC_LOW)
      |=> s_axi_rvalid && s_axi_rdata == 32'($past(pc_r[PCS_LOW_W-1:0]));
  endproperty
  a_low_read: assert property (p_low_read)  // [RULE_05] [RULE_06]
    else $error("low byte read wrong");

  c_irq:  cover property (irq_ack ##1 !insn_valid ##1 insn_valid);
  c_call: cover property (insn_valid && dec_call ##[2:20] insn_valid && dec_return);
  c_low:  cover property (low_wr ##2 insn_valid);
  c_skip: cover property (insn_valid && dec_skip ##2 insn_valid);

endmodule

`default_nettype wire

/* logic/pcs_pkg.sv */
// pcs_pkg: constants and types shared by the program counter sequencer files
package pcs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PCS_PC_W     = 13;
  localparam int PCS_INSN_W   = 16;
  localparam int PCS_TGT_W    = 11;
  localparam int PCS_LOW_W    = 8;
  localparam int PCS_AXI_AW   = 8;
  localparam int PCS_ADDR_LSB = 2;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] PCS_IDX_PC_LOW = 8'h02;
  localparam logic [7:0] PCS_IDX_PAGE   = 8'h0A;

  // ---------------------------------------------------------------
  // vectors and reset values
  // ---------------------------------------------------------------
  localparam logic [PCS_PC_W-1:0] PCS_RESET_VEC = 13'h0000;
  localparam logic [PCS_PC_W-1:0] PCS_IRQ_VEC   = 13'h0004;
  localparam logic [4:0]          PCS_PAGE_RST  = 5'h00;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] PCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // fetch state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_ST_RUN   = 2'b01,
    PCS_ST_FLUSH = 2'b10
  } pcs_fetch_t;

endpackage

/* logic/pcs_seq_if.sv */
// pcs_seq_if: bundle between the sequencer top and its next-address selector
`timescale 1ns/100ps
`default_nettype none

interface pcs_seq_if
  import pcs_pkg::*;
#(
  parameter int PC_W = PCS_PC_W
);
  logic [PC_W-1:0]      pc;
  pcs_fetch_t           st;
  logic                 irq;
  logic                 low_wr;
  logic [PCS_LOW_W-1:0] low_data;
  logic [PC_W-9:0]      page;
  logic                 jump;
  logic                 call;
  logic                 rtn;
  logic                 skip;
  logic [PCS_TGT_W-1:0] target;
  logic [PC_W-1:0]      rtn_addr;
  logic [PC_W-1:0]      pc_nxt;
  pcs_fetch_t           st_nxt;
  logic                 push;
  logic                 pop;
  logic                 irq_take;

  modport ctl (
    output pc, st, irq, low_wr, low_data, page, jump, call, rtn, skip, target, rtn_addr,
    input  pc_nxt, st_nxt, push, pop, irq_take
  );
  modport sel (
    input  pc, st, irq, low_wr, low_data, page, jump, call, rtn, skip, target, rtn_addr,
    output pc_nxt, st_nxt, push, pop, irq_take
  );
endinterface

`default_nettype wire

/* logic/pcs_next_addr.sv */
// pcs_next_addr: next program counter and fetch state selection
`timescale 1ns/100ps
`default_nettype none

module pcs_next_addr
  import pcs_pkg::*;
#(
  parameter int PC_W = PCS_PC_W
) (
  // sequencer bundle
  pcs_seq_if.sel sq
);

  logic dv;

  // ---------------------------------------------------------------
  // priority: decoder flow change, low-byte write, interrupt, step
  // ---------------------------------------------------------------
  always_comb begin
    unique case (sq.st)
      PCS_ST_RUN:   dv = 1'b1;
      PCS_ST_FLUSH: dv = 1'b0;
      default:      dv = 1'b0;
    endcase
    sq.pc_nxt   = sq.pc + PC_W'(1);                                   // [RULE_01]
    sq.st_nxt   = PCS_ST_RUN;                                         // [RULE_04]
    sq.push     = 1'b0;
    sq.pop      = 1'b0;
    sq.irq_take = 1'b0;
    if (dv && sq.rtn) begin
      sq.pc_nxt = sq.rtn_addr;                                        // [RULE_12] [RULE_02]
      sq.pop    = 1'b1;
      sq.st_nxt = PCS_ST_FLUSH;                                       // [RULE_18]
    end else if (dv && sq.call) begin
      sq.pc_nxt = {sq.page[PC_W-9:3], sq.target};                     // [RULE_11] [RULE_15] [RULE_14]
      sq.push   = 1'b1;
      sq.st_nxt = PCS_ST_FLUSH;
    end else if (dv && sq.jump) begin
      sq.pc_nxt = {sq.page[PC_W-9:3], sq.target};                     // [RULE_15] [RULE_02]
      sq.st_nxt = PCS_ST_FLUSH;
    end else if (dv && sq.skip) begin
      sq.st_nxt = PCS_ST_FLUSH;                                       // [RULE_03]
    end else if (sq.low_wr) begin
      sq.pc_nxt = {sq.page, sq.low_data};                             // [RULE_08] [RULE_16] [RULE_09]
      sq.st_nxt = PCS_ST_FLUSH;
    end else if (sq.irq) begin
      sq.pc_nxt   = PC_W'(PCS_IRQ_VEC);                               // [RULE_10]
      sq.push     = 1'b1;
      sq.irq_take = 1'b1;
      sq.st_nxt   = PCS_ST_FLUSH;
    end
  end

endmodule

`default_nettype wire

/* verif/pcs_fetch_model.sv */
// pcs_fetch_model: program flash image and return stack on the far side
`timescale 1ns/100ps
`default_nettype none

module pcs_fetch_model
  import pcs_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst,
  // program flash
  input  wire logic [PCS_PC_W-1:0] flash_addr,
  output logic [PCS_INSN_W-1:0]    flash_data,
  // return stack
  input  wire logic                stk_push,
  input  wire logic [PCS_PC_W-1:0] stk_push_data,
  input  wire logic                stk_pop,
  output logic [PCS_PC_W-1:0]      stk_pop_data
);
  logic [PCS_PC_W-1:0] stack_r [0:7];
  logic [2:0]          sp_r;

  // every address gives a distinct word
  assign flash_data   = {flash_addr[2:0] ^ 3'h5, flash_addr};
  assign stk_pop_data = stack_r[sp_r - 3'h1];

  always_ff @(posedge mclk) begin
    if (rst) begin
      sp_r <= 3'h0;
    end else if (stk_push) begin
      stack_r[sp_r] <= stk_push_data;
      sp_r          <= sp_r + 3'h1;
    end else if (stk_pop) begin
      sp_r <= sp_r - 3'h1;
    end
  end
endmodule

`default_nettype wire

/* verif/program_counter_sequencer_tb.sv */
// program_counter_sequencer_tb: self-checking bench for the sequencer top
`timescale 1ns/100ps
`default_nettype none

module program_counter_sequencer_tb import pcs_pkg::*;;
  localparam logic [2:0] K_NONE = 3'h0, K_JUMP = 3'h1, K_CALL = 3'h2;
  localparam logic [2:0] K_RTN = 3'h3, K_SKIP = 3'h4, K_IRQ = 3'h5;
  localparam logic [7:0] A_LOW = {PCS_IDX_PC_LOW[5:0], 2'b00};
  localparam logic [7:0] A_PAGE = {PCS_IDX_PAGE[5:0], 2'b00};
  typedef struct packed { logic [2:0] k; logic [10:0] t; logic [12:0] e; } pcs_row_t;

  logic        mclk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [12:0] flash_addr, stk_push_data, stk_pop_data, mpc;
  logic [15:0] flash_data, insn_word;
  logic        insn_valid, irq_ack, stk_push, stk_pop;
  logic        dec_jump = 1'b0, dec_call = 1'b0, dec_return = 1'b0, dec_skip = 1'b0;
  logic        irq_req = 1'b0;
  logic [10:0] dec_target = 11'h000;
  int          bad_count = 0, checks_done = 0;
  pcs_row_t    rows [10] = '{'{K_JUMP, 11'h300, 13'h0300}, '{K_NONE, 11'h000, 13'h0303},
    '{K_CALL, 11'h123, 13'h0123}, '{K_SKIP, 11'h000, 13'h0126}, '{K_RTN, 11'h000, 13'h0304},
    '{K_IRQ, 11'h000, 13'h0004}, '{K_RTN, 11'h000, 13'h0306}, '{K_JUMP, 11'h7FD, 13'h07FD},
    '{K_NONE, 11'h000, 13'h0800}, '{K_JUMP, 11'h010, 13'h0010}};

  always #5 mclk = ~mclk;

  pcs_top dut_u (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flash_addr, .flash_data, .insn_word, .insn_valid, .dec_jump, .dec_call,
    .dec_return, .dec_skip, .dec_target, .irq_req, .irq_ack, .stk_push, .stk_push_data,
    .stk_pop, .stk_pop_data);

  pcs_fetch_model fm_u (.mclk, .rst, .flash_addr, .flash_data, .stk_push, .stk_push_data,
    .stk_pop, .stk_pop_data);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] word_at(input logic [12:0] a);
    word_at = {a[2:0] ^ 3'h5, a};
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit got;
    got = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1'b1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
      end
    end
    if (!got) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit got;
    got = 1'b0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
      end
    end
    if (!got) begin
      bad_count++;
      give_verdict();
    end
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(flash_addr, 13'h0000);
    chk(insn_valid, 1'b0);
    @(posedge mclk);
    #1;
    chk(flash_addr, 13'h0001);
    chk(insn_word, word_at(13'h0000));
    mpc = 13'h0001;
  endtask

  // one decoder or interrupt event, then the idle cycle where one follows
  task automatic evt(input logic [2:0] k, input logic [10:0] t, input logic [12:0] e);
    @(posedge mclk);
    mpc = mpc + 13'h0001;
    dec_jump <= (k == K_JUMP);
    dec_call <= (k == K_CALL);
    dec_return <= (k == K_RTN);
    dec_skip <= (k == K_SKIP);
    irq_req <= (k == K_IRQ);
    dec_target <= t;
    #1;
    chk(stk_push, k == K_CALL || k == K_IRQ);
    chk(stk_pop, k == K_RTN);
    chk(irq_ack, k == K_IRQ);
    if (k == K_CALL || k == K_IRQ) chk(stk_push_data, mpc);
    @(posedge mclk);
    dec_call <= 1'b0;
    dec_return <= 1'b0;
    dec_skip <= 1'b0;
    irq_req <= 1'b0;
    dec_jump <= (k != K_NONE);
    dec_target <= ~t;
    #1;
    chk(flash_addr, e);
    chk(insn_valid, k == K_NONE);
    if (k == K_NONE) begin
      chk(insn_word, word_at(mpc));
      mpc = e;
    end else begin
      @(posedge mclk);
      dec_jump <= 1'b0;
      #1;
      chk(insn_valid, 1'b1);
      chk(insn_word, word_at(e));
      chk(flash_addr, e + 13'h0001);
      mpc = e + 13'h0001;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 10; i++) begin
      evt(rows[i].k, rows[i].t, rows[i].e);
      $display("row %0d done", i);
    end
    axi_rd(A_PAGE, 32'h0000_0000, PCS_RESP_OKAY);
    axi_wr(A_PAGE, 32'hFFFF_FFE8, 4'hF, PCS_RESP_OKAY);
    axi_rd(A_PAGE, 32'h0000_0008, PCS_RESP_OKAY);
    evt(K_JUMP, 11'h100, 13'h0900);
    $display("page test done");
    axi_wr(A_LOW, 32'h0000_0055, 4'hF, PCS_RESP_OKAY);
    #1;
    chk(insn_word, word_at(13'h0855));
    chk(flash_addr, 13'h0856);
    axi_wr(A_LOW, 32'h0000_00AA, 4'hE, PCS_RESP_OKAY);
    #1;
    chk(flash_addr, 13'h085A);
    axi_rd(A_LOW, 32'h0000_005B, PCS_RESP_OKAY);
    axi_wr(8'h10, 32'h0000_0011, 4'hF, PCS_RESP_SLVERR);
    axi_rd(8'h10, 32'h0000_0000, PCS_RESP_SLVERR);
    $display("low byte test done");
    // interrupt held through a jump waits for the idle cycle
    @(posedge mclk);
    dec_jump <= 1'b1;
    dec_target <= 11'h040;
    irq_req <= 1'b1;
    #1;
    chk(irq_ack, 1'b0);
    @(posedge mclk);
    dec_jump <= 1'b0;
    #1;
    chk(flash_addr, 13'h0840);
    chk(irq_ack, 1'b1);
    chk(stk_push_data, 13'h0840);
    @(posedge mclk);
    irq_req <= 1'b0;
    #1;
    chk(flash_addr, 13'h0004);
    chk(insn_valid, 1'b0);
    $display("interrupt wait test done");
    @(posedge mclk);
    do_reset();
    axi_rd(A_PAGE, 32'h0000_0000, PCS_RESP_OKAY);
    $display("second reset test done");
    give_verdict();
  end
endmodule

`default_nettype wire
